// ### include/shr_exec_map.vh
// constants for the status/halt/reset/trace execution core
`ifndef SHR_EXEC_MAP_VH
`define SHR_EXEC_MAP_VH

// trap vector byte addresses, then the halt restart offset and the halt status
`define SHR_VEC_UNIMPL      16'h0008
`define SHR_VEC_TRACE       16'h000C
`define SHR_VEC_PFAIL       16'h0014
`define SHR_RESTART_OFS     16'h0004
`define SHR_PS_HALT         8'hE0

// status word field positions
`define SHR_PS_N            3
`define SHR_PS_Z            2
`define SHR_PS_V            1
`define SHR_PS_C            0
`define SHR_PS_T            4
`define SHR_PS_PRI_HI       7
`define SHR_PS_PRI_LO       5

// opcodes, full word, bits 15:12 or bits 15:6
`define SHR_OP_HALT         16'h0000
`define SHR_OP_WAIT         16'h0001
`define SHR_OP_RTI          16'h0002
`define SHR_OP_RESET        16'h0005
`define SHR_OP_RTT          16'h0006
`define SHR_OP_MODEL        16'h0007
`define SHR_OP_MOV_HI       4'h1
`define SHR_OP_CLR          10'h028
`define SHR_OP_SXT          10'h037
`define SHR_OP_LDPS         10'h234
`define SHR_OP_STPS         10'h237

// reset values
`define SHR_PS_RESET        8'hE0
`define SHR_SP_RESET        16'h0200

// timing, clock period in picoseconds
`define SHR_CLK_PS          4000
`define SHR_BUS_CLEAR_N_NS         8400
`define SHR_PAUSE_NS        150
// cycle counts: the times above rounded up to whole clocks, sized for the counter
`define SHR_BUS_CLEAR_N_CYC        12'h834
`define SHR_PAUSE_CYC       12'h026

`endif

// ### hw/shr_exec.v
// execution core: status byte moves, halt trap, reset bus clear, trace and bus order
// How it works
// - copy_status_byte_out stores status low byte; N=bit7, Z=zero, V=0, C kept.
// - load_status_byte loads a source byte into status; source left untouched.
// - load_status_byte never sets the trace bit 4.
// - unimplemented opcodes trap through vector 10 octal.
// - halt pushes status and pc, pc=restart (start+4), status=340.
// - reset drives bus_clear_n low 8.4 us, then 150 ns idle, then fetch.
// - reset runs a priority sample transaction; flags and registers unchanged.
// - bus clear and pause lengths are counted in clock cycles.
// - power fail during reset waits until the bus clear sequence ends.
// - trace bit set only by returns, traps and exception entry.
// - return_from_interrupt setting trace traps via 14 before next instruction.
// - return_from_trap setting trace runs one more instruction before trapping.
// - pending trace trap is taken before a pending interrupt.
// - wait with trace set exits, services trace, continues after the wait.
// - every write to memory is preceded by a read of that address.
// - move: fetch, source, address, read, write; zero_destination, sign_extend: fetch, address, read, write.
// - address 177776 is ordinary memory; unanswered accesses raise no error.
// - read_model_code puts the model code in low byte of R0; flags kept.
`timescale 1ns/1ps
`default_nettype none
`include "shr_exec_map.vh"

module shr_exec #(
    parameter [15:0] START_ADDR = 16'h0000,
    parameter [7:0]  MODEL_CODE = 8'h5A     // arbitrary identification value
) (
    input  wire        clk,
    input  wire        reset,
    input  wire [15:0] bus_rdata,
    input  wire        power_fail_request,
    input  wire        irq_req,
    input  wire [2:0]  irq_prio,
    input  wire [7:0]  irq_vector,
    output reg  [15:0] bus_addr,
    output reg  [15:0] bus_wdata,
    output reg         bus_rd,
    output reg         bus_wr,
    output reg         bus_byte,
    output reg         bus_clear_n,
    output reg         priority_sample_transaction,
    output reg         irq_ack,
    output reg  [7:0]  processor_status_word
);

    localparam [12:0] ST_BOUND = 13'h0001;
    localparam [12:0] ST_FETCH = 13'h0002;
    localparam [12:0] ST_DEC   = 13'h0004;
    localparam [12:0] ST_SRC   = 13'h0008;
    localparam [12:0] ST_EXEC  = 13'h0010;
    localparam [12:0] ST_DRD   = 13'h0020;
    localparam [12:0] ST_PSH   = 13'h0040;
    localparam [12:0] ST_PSW   = 13'h0080;
    localparam [12:0] ST_VPC   = 13'h0100;
    localparam [12:0] ST_VPS   = 13'h0200;
    localparam [12:0] ST_POP   = 13'h0400;
    localparam [12:0] ST_BUS_CLEAR_N  = 13'h0800;
    localparam [12:0] ST_WAIT  = 13'h1000;

    localparam [11:0] BUS_CLEAR_N_CYC  = `SHR_BUS_CLEAR_N_CYC;
    localparam [11:0] PAUSE_CYC = `SHR_PAUSE_CYC;

    reg [12:0] state_reg;
    reg [15:0] gr [0:7];        // r6 stack, r7 program counter
    reg [15:0] ir_reg;
    reg [15:0] opnd_reg;
    reg [15:0] vec_reg;
    reg        halt_trap_reg;
    reg        second_reg;      // second push / second pop
    reg        pause_reg;
    reg [11:0] cnt_reg;
    reg        rtt_skip_reg;
    reg        pf_pend_reg;
    reg [1:0]  pf_sync_reg;
    reg        pf_last_reg;
    reg [1:0]  irq_sync_reg;
    reg [2:0]  prio_s1_reg, prio_s2_reg;
    reg [7:0]  vec_s1_reg, vec_s2_reg;
    integer    i;

    wire [2:0]  dm = ir_reg[5:3];
    wire [2:0]  dr = ir_reg[2:0];
    wire [7:0]  ps = processor_status_word;
    wire [15:0] sp = gr[6];
    wire [15:0] pc = gr[7];
    wire [15:0] f_ir = bus_rdata;

    wire is_mov  = ir_reg[15:12] == `SHR_OP_MOV_HI;
    wire is_clr  = ir_reg[15:6] == `SHR_OP_CLR;
    wire is_sxt  = ir_reg[15:6] == `SHR_OP_SXT;
    wire is_ldps = ir_reg[15:6] == `SHR_OP_LDPS;
    wire is_stps = ir_reg[15:6] == `SHR_OP_STPS;
    // load_status_byte carries its source in the low six bits
    wire [2:0]  sm = is_ldps ? ir_reg[5:3] : ir_reg[11:9];
    wire [2:0]  sr = is_ldps ? ir_reg[2:0] : ir_reg[8:6];
    // only register and register-deferred modes are carried here
    wire src_ok  = sm[2:1] == 2'b00;
    wire dst_ok  = dm[2:1] == 2'b00;

    wire pf_edge  = pf_sync_reg[1] & ~pf_last_reg;
    wire irq_take = irq_sync_reg[1] && (prio_s2_reg > ps[`SHR_PS_PRI_HI:`SHR_PS_PRI_LO]);

    // byte out of a bus word by address lane
    wire [7:0]  src_byte = opnd_reg[0] ? bus_rdata[15:8] : bus_rdata[7:0];

    // result and flags of move and the single-operand group
    reg [15:0] res;
    reg [7:0]  ps_new;
    reg        res_byte;
    always @* begin
        res      = opnd_reg;
        ps_new   = ps;
        res_byte = 1'b0;
        if (is_mov) begin
            ps_new[`SHR_PS_N] = opnd_reg[15];
            ps_new[`SHR_PS_Z] = opnd_reg == 16'h0000;
            ps_new[`SHR_PS_V] = 1'b0;
        end else if (is_clr) begin
            res = 16'h0000;
            ps_new[3:0] = 4'h4;
        end else if (is_sxt) begin
            res = {16{ps[`SHR_PS_N]}};
            ps_new[`SHR_PS_Z] = ~ps[`SHR_PS_N];
            ps_new[`SHR_PS_V] = 1'b0;
        end else if (is_stps) begin
            res      = {{8{ps[7]}}, ps};
            res_byte = 1'b1;
            ps_new[`SHR_PS_N] = ps[7];
            ps_new[`SHR_PS_Z] = ps == 8'h00;
            ps_new[`SHR_PS_V] = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state_reg     <= ST_BOUND;
            for (i = 0; i < 8; i = i + 1)
                gr[i] <= 16'h0000;
            gr[7]         <= START_ADDR;
            ir_reg        <= 16'h0000;
            opnd_reg      <= 16'h0000;
            vec_reg       <= 16'h0000;
            halt_trap_reg <= 1'b0;
            second_reg    <= 1'b0;
            pause_reg     <= 1'b0;
            cnt_reg       <= 12'h000;
            rtt_skip_reg  <= 1'b0;
            pf_pend_reg   <= 1'b0;
            pf_sync_reg   <= 2'b00;
            pf_last_reg   <= 1'b0;
            irq_sync_reg  <= 2'b00;
            prio_s1_reg   <= 3'h0;
            prio_s2_reg   <= 3'h0;
            vec_s1_reg    <= 8'h00;
            vec_s2_reg    <= 8'h00;
            bus_addr      <= 16'h0000;
            bus_wdata     <= 16'h0000;
            bus_rd        <= 1'b0;
            bus_wr        <= 1'b0;
            bus_byte      <= 1'b0;
            bus_clear_n   <= 1'b1;
            priority_sample_transaction <= 1'b0;
            irq_ack       <= 1'b0;
            processor_status_word <= `SHR_PS_RESET;
        end else begin
            pf_sync_reg  <= {pf_sync_reg[0], power_fail_request};
            irq_sync_reg <= {irq_sync_reg[0], irq_req};
            prio_s1_reg  <= irq_prio;
            prio_s2_reg  <= prio_s1_reg;
            vec_s1_reg   <= irq_vector;
            vec_s2_reg   <= vec_s1_reg;
            pf_last_reg  <= pf_sync_reg[1];
            if (pf_edge)
                pf_pend_reg <= 1'b1;
            bus_rd  <= 1'b0;
            bus_wr  <= 1'b0;
            irq_ack <= 1'b0;
            priority_sample_transaction <= 1'b0;
            gr[7] <= pc;
            case (state_reg)
                ST_BOUND: begin
                    halt_trap_reg <= 1'b0;
                    second_reg    <= 1'b0;
                    // power fail first, then trace, then interrupts
                    if (pf_pend_reg) begin
                        pf_pend_reg <= pf_edge;
                        vec_reg     <= `SHR_VEC_PFAIL;
                        state_reg   <= ST_PSH;
                    end else if (ps[`SHR_PS_T] && !rtt_skip_reg) begin
                        vec_reg   <= `SHR_VEC_TRACE;
                        state_reg <= ST_PSH;
                    end else if (irq_take) begin
                        irq_ack   <= 1'b1;
                        vec_reg   <= {8'h00, vec_s2_reg};
                        state_reg <= ST_PSH;
                    end else begin
                        rtt_skip_reg <= 1'b0;
                        bus_addr  <= pc;
                        bus_rd    <= 1'b1;
                        bus_byte  <= 1'b0;
                        gr[7]     <= pc + 16'h0002;
                        state_reg <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    ir_reg    <= f_ir;
                    state_reg <= ST_DEC;
                end
                ST_DEC: begin
                    state_reg <= ST_BOUND;
                    if (ir_reg == `SHR_OP_HALT) begin
                        halt_trap_reg <= 1'b1;
                        state_reg     <= ST_PSH;
                    end else if (ir_reg == `SHR_OP_WAIT) begin
                        state_reg <= ST_WAIT;
                    end else if (ir_reg == `SHR_OP_RTI || ir_reg == `SHR_OP_RTT) begin
                        bus_addr  <= sp;
                        bus_rd    <= 1'b1;
                        gr[6]     <= sp + 16'h0002;
                        state_reg <= ST_POP;
                    end else if (ir_reg == `SHR_OP_RESET) begin
                        // flags, general registers and pc untouched throughout
                        priority_sample_transaction <= 1'b1;
                        bus_clear_n <= 1'b0;
                        cnt_reg     <= BUS_CLEAR_N_CYC - 12'h001;
                        pause_reg   <= 1'b0;
                        state_reg   <= ST_BUS_CLEAR_N;
                    end else if (ir_reg == `SHR_OP_MODEL) begin
                        gr[0][7:0] <= MODEL_CODE;
                    end else if ((is_mov || is_ldps) && src_ok && dst_ok) begin
                        opnd_reg <= gr[sr];
                        if (sm[0]) begin
                            bus_addr  <= gr[sr];
                            bus_rd    <= 1'b1;
                            bus_byte  <= is_ldps;
                            state_reg <= ST_SRC;
                        end else begin
                            state_reg <= ST_EXEC;
                        end
                    end else if ((is_clr || is_sxt || is_stps) && dst_ok) begin
                        state_reg <= ST_EXEC;
                    end else begin
                        vec_reg   <= `SHR_VEC_UNIMPL;
                        state_reg <= ST_PSH;
                    end
                end
                ST_SRC: begin
                    opnd_reg  <= is_ldps ? {8'h00, src_byte} : bus_rdata;
                    state_reg <= ST_EXEC;
                end
                ST_EXEC: begin
                    state_reg <= ST_BOUND;
                    if (is_ldps) begin
                        // trace bit is kept, never taken from the operand
                        processor_status_word <= {opnd_reg[7:5], ps[`SHR_PS_T],
                                                  opnd_reg[3:0]};
                    end else begin
                        processor_status_word <= ps_new;
                        if (!dm[0]) begin
                            gr[dr] <= res;
                        end else begin
                            // no decode of any address, 177776 included
                            bus_addr  <= gr[dr];
                            bus_rd    <= 1'b1;
                            bus_byte  <= res_byte;
                            opnd_reg  <= res;
                            state_reg <= ST_DRD;
                        end
                    end
                end
                ST_DRD: begin
                    // read data ignored; nothing answers with an error
                    bus_wr    <= 1'b1;
                    bus_wdata <= bus_byte ? {2{opnd_reg[7:0]}} : opnd_reg;
                    state_reg <= ST_BOUND;
                end
                ST_PSH: begin
                    gr[6]     <= sp - 16'h0002;
                    bus_addr  <= sp - 16'h0002;
                    bus_rd    <= 1'b1;
                    bus_byte  <= 1'b0;
                    state_reg <= ST_PSW;
                end
                ST_PSW: begin
                    bus_wr     <= 1'b1;
                    bus_wdata  <= second_reg ? pc : {8'h00, ps};
                    second_reg <= ~second_reg;
                    state_reg  <= second_reg ? ST_VPC : ST_PSH;
                    if (second_reg && halt_trap_reg) begin
                        gr[7] <= START_ADDR + `SHR_RESTART_OFS;
                        processor_status_word <= `SHR_PS_HALT;
                        state_reg <= ST_BOUND;
                    end
                end
                ST_VPC: begin
                    // pc push is on the bus now; the vector read follows it
                    bus_addr  <= vec_reg;
                    bus_rd    <= 1'b1;
                    state_reg <= ST_VPS;
                end
                ST_VPS: begin
                    if (!second_reg) begin
                        gr[7]      <= bus_rdata;
                        bus_addr   <= vec_reg + 16'h0002;
                        bus_rd     <= 1'b1;
                        second_reg <= 1'b1;
                    end else begin
                        // entry status may carry the trace bit
                        processor_status_word <= bus_rdata[7:0];
                        state_reg <= ST_BOUND;
                    end
                end
                ST_POP: begin
                    if (!second_reg) begin
                        gr[7]      <= bus_rdata;
                        bus_addr   <= sp;
                        bus_rd     <= 1'b1;
                        gr[6]      <= sp + 16'h0002;
                        second_reg <= 1'b1;
                    end else begin
                        processor_status_word <= bus_rdata[7:0];
                        rtt_skip_reg <= ir_reg == `SHR_OP_RTT;
                        state_reg    <= ST_BOUND;
                    end
                end
                ST_BUS_CLEAR_N: begin
                    // power fail only latches here; taken at the boundary after
                    if (cnt_reg != 12'h000) begin
                        cnt_reg <= cnt_reg - 12'h001;
                    end else if (!pause_reg) begin
                        bus_clear_n <= 1'b1;
                        pause_reg   <= 1'b1;
                        cnt_reg     <= PAUSE_CYC - 12'h001;
                    end else begin
                        state_reg <= ST_BOUND;
                    end
                end
                ST_WAIT: begin
                    if (ps[`SHR_PS_T] || pf_pend_reg || irq_take)
                        state_reg <= ST_BOUND;
                end
                default: state_reg <= ST_BOUND;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### test/shr_exec_properties.sv
// concurrent checks on the execution core's bus order and bus-clear sequence
`timescale 1ns/1ps
`default_nettype none
`include "shr_exec_map.vh"
module shr_exec_properties (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] bus_rdata,
    input wire logic        power_fail_request,
    input wire logic        irq_req,
    input wire logic [2:0]  irq_prio,
    input wire logic [7:0]  irq_vector,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic        bus_rd,
    input wire logic        bus_wr,
    input wire logic        bus_byte,
    input wire logic        bus_clear_n,
    input wire logic        priority_sample_transaction,
    input wire logic        irq_ack,
    input wire logic [7:0]  processor_status_word
);
    localparam int BUS_CLEAR_N_CYC  = `SHR_BUS_CLEAR_N_CYC;
    localparam int PAUSE_CYC = `SHR_PAUSE_CYC;
    logic [15:0] low_cnt_reg;
    logic [7:0]  quiet_cnt_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // counters rather than repetition: the clear pulse is thousands of cycles
    always_ff @(posedge clk) begin
        if (reset) begin
            low_cnt_reg <= 16'h0000;
            quiet_cnt_reg <= 8'h00;
        end else begin
            low_cnt_reg <= bus_clear_n ? 16'h0000 : low_cnt_reg + 16'h0001;
            if ($rose(bus_clear_n)) begin
                quiet_cnt_reg <= 8'(PAUSE_CYC - 1);
            end else if (quiet_cnt_reg != 8'h00) begin
                quiet_cnt_reg <= quiet_cnt_reg - 8'h01;
            end
        end
    end
    sequence s_clear_start;
        $fell(bus_clear_n);
    endsequence
    sequence s_clear_end;
        $rose(bus_clear_n);
    endsequence
    AST_WR_AFTER_RD: assert property (bus_wr |-> $past(bus_rd))
        else $error("write without a read in the cycle before");
    AST_WR_SAME_ADDR: assert property (bus_wr |-> bus_addr == $past(bus_addr))
        else $error("write address differs from preceding read");
    AST_CLEAR_WIDTH: assert property (s_clear_end |-> low_cnt_reg == BUS_CLEAR_N_CYC)
        else $error("bus clear pulse has wrong length");
    AST_CLEAR_COUNTED: assert property (!bus_clear_n |-> low_cnt_reg < BUS_CLEAR_N_CYC)
        else $error("bus clear held past its cycle count");
    AST_PAUSE_QUIET: assert property (($rose(bus_clear_n) || quiet_cnt_reg != 8'h00) |-> !bus_rd && !bus_wr)
        else $error("bus activity inside the pause after bus clear");
    AST_PF_DEFERRED: assert property ((!bus_clear_n || quiet_cnt_reg != 8'h00) |-> !(bus_rd && bus_addr == `SHR_VEC_PFAIL))
        else $error("power fail taken inside the bus clear sequence");
    AST_SAMPLE_AT_CLEAR: assert property (s_clear_start |-> priority_sample_transaction || $past(priority_sample_transaction))
        else $error("bus clear started without a priority sample");
    AST_FLAGS_HELD: assert property ((!bus_clear_n) [*2] |-> $stable(processor_status_word))
        else $error("status changed during bus clear");
    AST_BYTE_LANES: assert property ((bus_wr && bus_byte) |-> bus_wdata[15:8] == bus_wdata[7:0])
        else $error("byte store not on both lanes");
endmodule
bind shr_exec shr_exec_properties u_props (.clk(clk), .reset(reset), .bus_rdata(bus_rdata),
    .power_fail_request(power_fail_request), .irq_req(irq_req), .irq_prio(irq_prio),
    .irq_vector(irq_vector), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_byte(bus_byte), .bus_clear_n(bus_clear_n),
    .priority_sample_transaction(priority_sample_transaction), .irq_ack(irq_ack),
    .processor_status_word(processor_status_word));
`default_nettype wire

// ### test/shr_mem_model.sv
// memory on the core's data/address bus, holding the test program
`timescale 1ns/1ps
`default_nettype none
module shr_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic        bus_byte,
    input  wire logic        poke_wr,
    input  wire logic [15:0] poke_addr,
    input  wire logic [15:0] poke_data,
    output logic      [15:0] bus_rdata
);
    logic [15:0] mem [0:32767];
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 16'h0000;
        end
        mem[16'h0008 / 2] = 16'h1100;
        mem[16'h000A / 2] = 16'h00E0;
        mem[16'h000C / 2] = 16'h1200;
        mem[16'h000E / 2] = 16'h00E0;
        mem[16'h0014 / 2] = 16'h1300;
        mem[16'h0016 / 2] = 16'h0000;
        mem[16'h1000 / 2] = 16'h0007;
        mem[16'h1002 / 2] = 16'h100A;
        mem[16'h1004 / 2] = 16'h0A0A;
        mem[16'h1006 / 2] = 16'h8D00;
        mem[16'h1008 / 2] = 16'h8DCA;
        mem[16'h100A / 2] = 16'h7000;
        mem[16'h100C / 2] = 16'h0DCA;
        mem[16'h100E / 2] = 16'h0005;
        mem[16'h1100 / 2] = 16'h0002;
        mem[16'h1200 / 2] = 16'h0006;
        mem[16'h1300 / 2] = 16'h0000;
    end
    // read data stand while bus_rd is high, which is when the core takes them;
    // outside a read the lines show the inverse so stale data never looks valid
    assign bus_rdata = bus_rd ? mem[bus_addr[15:1]] : ~mem[bus_addr[15:1]];
    always @(posedge clk) begin
        // reads have no side effect, so the read ahead of each write is harmless
        if (poke_wr) begin
            mem[poke_addr[15:1]] <= poke_data;
        end else if (bus_wr && !bus_byte) begin
            mem[bus_addr[15:1]] <= bus_wdata;
        end else if (bus_wr && bus_addr[0]) begin
            mem[bus_addr[15:1]][15:8] <= bus_wdata[15:8];
        end else if (bus_wr) begin
            mem[bus_addr[15:1]][7:0] <= bus_wdata[7:0];
        end
    end
endmodule
`default_nettype wire

// ### test/shr_exec_test.sv
// self-checking bench: runs a short program through the core and watches the bus
`timescale 1ns/1ps
`default_nettype none
module shr_exec_test;
    localparam logic [15:0] START = 16'h1000;
    localparam logic [7:0]  MODEL = 8'h3C;   // arbitrary identification value
    localparam int          BUS_CLEAR_N  = 8400 * 1000 / 4000;
    localparam int          PAUSE = (150 * 1000 + 3999) / 4000;
    localparam logic [7:0]  ST_LD = {MODEL[7:5], 1'b0, MODEL[3:0]};
    localparam logic [7:0]  ST_SV = {ST_LD[7:4], ST_LD[7], ST_LD == 8'h00, 1'b0, ST_LD[0]};
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        power_fail_request = 1'b0;
    logic        poke_wr = 1'b0;
    logic [15:0] poke_addr = 16'h0000;
    logic [15:0] poke_data = 16'h0000;
    logic [15:0] bus_rdata, bus_addr, bus_wdata, seen_data;
    logic        bus_rd, bus_wr, bus_byte, bus_clear_n, seen_byte;
    logic        priority_sample_transaction;
    logic [7:0]  processor_status_word, seen_psw;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    shr_exec #(.START_ADDR(START), .MODEL_CODE(MODEL)) uut (.clk(clk), .reset(reset),
        .bus_rdata(bus_rdata), .power_fail_request(power_fail_request), .irq_req(1'b0),
        .irq_prio(3'h0), .irq_vector(8'h00), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_byte(bus_byte), .bus_clear_n(bus_clear_n),
        .priority_sample_transaction(priority_sample_transaction), .irq_ack(),
        .processor_status_word(processor_status_word));
    shr_mem_model mem (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_byte(bus_byte), .poke_wr(poke_wr),
        .poke_addr(poke_addr), .poke_data(poke_data), .bus_rdata(bus_rdata));
    always #2 clk = ~clk;
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            $display("[FAIL] run length expected below %0d seen %0d", 20000, cycles);
            close_out();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // waits for a read (or write) at either address; FFFF marks none found
    task automatic seek(input logic [15:0] a, input logic [15:0] b, input logic wr,
                        output logic [15:0] hit);
        hit = 16'hFFFF;
        for (int n = 0; n < 4000; n++) begin
            @(posedge clk);
            if (((wr ? bus_wr : bus_rd) === 1'b1) && (bus_addr === a || bus_addr === b)) begin
                hit = bus_addr;
                seen_data = bus_wdata;
                seen_byte = bus_byte;
                seen_psw = processor_status_word;
                break;
            end
        end
    endtask
    task automatic t_move_clear;
        logic [15:0] h;
        seek(16'h0000, 16'h0000, 1'b1, h);
        chk("move target", 16'h0000, h);
        chk("model code stored", {8'h00, MODEL}, seen_data);
        seek(16'h0000, 16'h0000, 1'b1, h);
        chk("clear data", 16'h0000, seen_data);
    endtask
    task automatic t_status;
        logic [15:0] h;
        seek(START + 16'h0008, START + 16'h0008, 1'b0, h);
        chk("status after load", {8'h00, ST_LD}, {8'h00, seen_psw});
        seek(16'h0000, 16'h0000, 1'b1, h);
        chk("status byte stored", {ST_LD, ST_LD}, seen_data);
        chk("byte access", 16'h0001, {15'h0000, seen_byte});
        seek(START + 16'h000A, START + 16'h000A, 1'b0, h);
        chk("flags after store", {8'h00, ST_SV}, {8'h00, seen_psw});
    endtask
    task automatic t_unimpl;
        logic [15:0] h;
        seek(16'hFFFE, 16'hFFFE, 1'b1, h);
        chk("pushed status at top word", {8'h00, ST_SV}, seen_data);
        seek(16'h0008, START + 16'h000C, 1'b0, h);
        chk("unimplemented vector", 16'h0008, h);
        seek(16'h1100, 16'h1100, 1'b0, h);
        poke_addr <= 16'hFFFE;
        poke_data <= 16'h0010;
        poke_wr <= 1'b1;
        @(posedge clk);
        poke_wr <= 1'b0;
    endtask
    task automatic t_returns;
        logic [15:0] h;
        seek(16'h000C, START + 16'h000C, 1'b0, h);
        chk("trace before next after rti", 16'h000C, h);
        seek(16'h1200, 16'h1200, 1'b0, h);
        seek(16'h000C, START + 16'h000C, 1'b0, h);
        chk("one instruction after rtt", START + 16'h000C, h);
        seek(16'h000C, START + 16'h000E, 1'b0, h);
        chk("trace after that instruction", 16'h000C, h);
    endtask
    task automatic t_reset_pf;
        logic [15:0] h;
        logic [7:0]  psw0;
        logic        sampled;
        int          low;
        int          quiet;
        seek(START + 16'h000E, START + 16'h000E, 1'b0, h);
        sampled = 1'b0;
        for (quiet = 0; quiet < 40 && bus_clear_n !== 1'b0; quiet++) begin
            @(posedge clk);
            sampled = sampled | (priority_sample_transaction === 1'b1);
        end
        power_fail_request <= 1'b1;
        psw0 = processor_status_word;
        for (low = 0; low < 3000 && bus_clear_n !== 1'b1; low++) begin
            @(posedge clk);
            sampled = sampled | (priority_sample_transaction === 1'b1);
        end
        chk("bus clear cycles", 16'(BUS_CLEAR_N), 16'(low));
        chk("priority sample", 16'h0001, {15'h0000, sampled});
        chk("status across clear", {8'h00, psw0}, {8'h00, processor_status_word});
        for (quiet = 0; quiet < 200 && bus_rd !== 1'b1 && bus_wr !== 1'b1; quiet++) begin
            @(posedge clk);
        end
        chk("pause long enough", 16'h0001, {15'h0000, quiet >= PAUSE});
        seek(16'h0014, 16'h0014, 1'b0, h);
        chk("power fail after clear", 16'h0014, h);
        power_fail_request <= 1'b0;
    endtask
    task automatic t_halt;
        logic [15:0] h;
        seek(16'h1300, 16'h1300, 1'b0, h);
        seek(START + 16'h0004, START + 16'h0004, 1'b0, h);
        chk("restart fetch", START + 16'h0004, h);
        chk("status after halt", 16'h00E0, {8'h00, seen_psw});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_move_clear();
        t_status();
        t_unimpl();
        t_returns();
        t_reset_pf();
        t_halt();
        close_out();
    end
endmodule
`default_nettype wire
